// >>> adcp_top.sv
// Control pins of the converter: serial link, port register, two general-purpose pins and clock output.
// Operation
// RULE_01: The host supplies the serial clock, and every transfer in or out is timed by it.
// RULE_02: With select held low the device runs as a 3-wire link on clock, data in and data out.
// RULE_03: On a shared bus the device responds only while its select is low.
// RULE_04: The select input can frame each 8-bit unit of the serial transfer; a release after the command unit returns the sequencer to ST_CMD.
// RULE_05: Reset low returns control, interface, filter, modulator and all registers to power-on state.
// RULE_06: Reset leaves the clock oscillator and its output running; everything else is reset.
// RULE_07: The master-clock output is an inverted copy of the master clock unless switched off.
// RULE_08: Pin zero follows its direction bit and its level is read or written through its value bit.
// RULE_09: Pin one follows its own direction bit and its level is read or written through its value bit.
// RULE_10: With the synchronization bit set, pin one acts as the filter and modulator sync input.
// RULE_11: An output pin drives its value bit; an input pin reads back its sampled level.
`timescale 1ns/10ps
module adcp_top
   import adcp_pkg::*;
(
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic sclk,
   input  wire logic cs_n,
   input  wire logic din,
   output logic      dout,
   output logic      dout_oe,
   input  wire logic mclk_out_off,
   output logic      master_clock_out,
   input  wire logic gp_pin_zero_i,
   output logic      gp_pin_zero_o,
   output logic      gp_pin_zero_oe,
   input  wire logic sync_or_gp_pin_one_i,
   output logic      sync_or_gp_pin_one_o,
   output logic      sync_or_gp_pin_one_oe,
   output logic      sync_hold,
   output logic      ready_fn,
   output logic [7:0] io_port_status
);

   // Link wires and synchronised inputs.
   logic [BYTE_W-1:0] rx_byte;
   logic [BYTE_W-1:0] tx_q;
   logic              rx_toggle;
   logic [3:0]        sync_in;
   logic [3:0]        sync_out;
   logic              tog_prev_q;
   logic              mclk_en_q;
   adcp_state_t       state_q;
   adcp_state_t       state_d;
   logic [ADDR_W-1:0] addr_q;

   // Port register fields.
   logic              val0_q;
   logic              val1_q;
   logic              dir0_q;
   logic              dir1_q;
   logic              rdyfn_q;
   logic              syncen_q;

   adcp_link #(
      .BW (BYTE_W)
   ) u_link (
      .sclk      (sclk),
      .arst_n    (arst_n),
      .cs_n      (cs_n),
      .din       (din),
      .tx_byte   (tx_q),
      .rx_byte   (rx_byte),
      .rx_toggle (rx_toggle),
      .dout      (dout),
      .dout_oe   (dout_oe)
   );

   // Pins and the byte-done toggle come from other clocks, so all pass two flops.
   assign sync_in = {rx_toggle, cs_n, sync_or_gp_pin_one_i, gp_pin_zero_i};

   adcp_sync #(
      .W (4)
   ) u_sync (
      .clk    (mclk),
      .arst_n (arst_n),
      .d      (sync_in),
      .q      (sync_out)
   );

   // The port register read-back is built for 8-bit units; refuse any other unit width.
   if (BYTE_W != $bits(io_port_status)) begin : g_width_check
      $error("adcp_top: port register logic needs units as wide as the status port");
   end

   // Read-back of one pin: an input returns its sampled level, an output its stored value.
   function automatic logic pin_readback(input logic dir_in, input logic pin_s, input logic val);
      return dir_in ? pin_s : val;
   endfunction

   // Field update on a port register write; without a write the field keeps its value.
   function automatic logic field_next(input logic wr, input logic new_bit, input logic cur);
      return wr ? new_bit : cur;
   endfunction

   // Decoded events; the received byte is stable for a whole byte time after its toggle.
   wire               pin0_s    = sync_out[0];
   wire               pin1_s    = sync_out[1];
   wire               cs_hi_s   = sync_out[2];
   wire               byte_evt  = sync_out[3] ^ tog_prev_q;
   wire               cmd_ok    = ~rx_byte[CMD_ZERO_BIT];
   wire               cmd_read  = rx_byte[CMD_RW_BIT];
   wire [ADDR_W-1:0]  cmd_addr  = rx_byte[ADDR_W-1:0];
   wire               cmd_is_io = (cmd_addr == ADDR_IO_PORT);
   wire               io_wr     = (state_q == ST_WR) && byte_evt && (addr_q == ADDR_IO_PORT);

   // Read-back selects the sampled level for inputs and the stored value for outputs.
   wire               p0_bit    = pin_readback(dir0_q, pin0_s, val0_q); // RULE_08 RULE_11
   wire               p1_bit    = pin_readback(dir1_q, pin1_s, val1_q); // RULE_09 RULE_11
   wire [7:0]         io_rd     = {p0_bit, p1_bit, dir0_q, dir1_q, rdyfn_q, 2'b00, syncen_q};

   // Next field values on a port register write.
   wire               val0_d    = field_next(io_wr, rx_byte[IO_P0_BIT], val0_q);
   wire               val1_d    = field_next(io_wr, rx_byte[IO_P1_BIT], val1_q);
   wire               dir0_d    = field_next(io_wr, rx_byte[IO_P0DIR_BIT], dir0_q); // RULE_08
   wire               dir1_d    = field_next(io_wr, rx_byte[IO_P1DIR_BIT], dir1_q); // RULE_09
   wire               rdyfn_d   = field_next(io_wr, rx_byte[IO_RDYFN_BIT], rdyfn_q);
   wire               syncen_d  = field_next(io_wr, rx_byte[IO_SYNC_BIT], syncen_q); // RULE_10

   // In sync mode pin one is forced to an input whatever its direction bit says.
   wire               oe0_d     = ~dir0_d; // RULE_08
   wire               oe1_d     = ~dir1_d & ~syncen_d; // RULE_09 RULE_10
   wire               hold_d    = syncen_q & ~sync_or_gp_pin_one_oe & ~pin1_s; // RULE_10

   // Command sequencer: a command byte, then one data byte in or out.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_CMD: begin
            if (byte_evt && cmd_ok) begin
               state_d = cmd_read ? ST_RD : ST_WR;
            end
         end
         ST_WR, ST_RD: begin
            if (byte_evt) begin
               state_d = ST_CMD;
            end
         end
      endcase
      // A released select ends the frame; a byte finished in the same cycle is handled first.
      if (cs_hi_s && !byte_evt) begin
         state_d = ST_CMD; // RULE_04
      end
   end

   // Sequencer, address and reply registers.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_q    <= ST_CMD; // RULE_05
         tog_prev_q <= 1'b0;
         addr_q     <= '0;
         tx_q       <= RST_TX;
      end else begin
         state_q    <= state_d;
         tog_prev_q <= sync_out[3];
         if (state_q == ST_CMD && byte_evt && cmd_ok) begin
            addr_q <= cmd_addr;
            tx_q   <= cmd_is_io ? io_rd : RD_UNMAPPED; // RULE_08 RULE_09
         end
      end
   end

   // Port register and pin drivers; every field returns to its power-on value in reset.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         val0_q                <= RST_VAL; // RULE_05
         val1_q                <= RST_VAL;
         dir0_q                <= RST_DIR;
         dir1_q                <= RST_DIR;
         rdyfn_q               <= RST_RDYFN;
         syncen_q              <= RST_SYNC;
         gp_pin_zero_oe        <= ~RST_DIR;
         sync_or_gp_pin_one_oe <= ~RST_DIR;
         sync_hold             <= 1'b0;
      end else begin
         val0_q                <= val0_d;
         val1_q                <= val1_d;
         dir0_q                <= dir0_d;
         dir1_q                <= dir1_d;
         rdyfn_q               <= rdyfn_d;
         syncen_q              <= syncen_d;
         gp_pin_zero_oe        <= oe0_d; // RULE_11
         sync_or_gp_pin_one_oe <= oe1_d; // RULE_11
         sync_hold             <= hold_d; // RULE_10
      end
   end

   // Drivers mirror the stored fields; the status port registers the read-back value.
   assign gp_pin_zero_o        = val0_q; // RULE_11
   assign sync_or_gp_pin_one_o = val1_q; // RULE_11
   assign ready_fn             = rdyfn_q;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         io_port_status <= '0;
      end else begin
         io_port_status <= io_rd;
      end
   end

   // The output enable resets to one so the clock output keeps running through reset.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mclk_en_q <= RST_MCLK_EN; // RULE_06
      end else begin
         mclk_en_q <= ~mclk_out_off; // RULE_07
      end
   end

   // The enable changes only while the clock is high, when the inverted output is already low,
   // so the gate cannot cut a pulse short.
   assign master_clock_out = mclk_en_q & ~mclk; // RULE_07

   // Checks on the port register, sequencer and clock output.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   sequence s_cmd_write;
      (state_q == ST_CMD) && byte_evt && cmd_ok && !cmd_read;
   endsequence

   sequence s_io_read;
      (state_q == ST_CMD) && byte_evt && cmd_ok && cmd_read && cmd_is_io;
   endsequence

   sequence s_cmd_read;
      (state_q == ST_CMD) && byte_evt && cmd_ok && cmd_read;
   endsequence

   sequence s_bad_cmd;
      (state_q == ST_CMD) && byte_evt && !cmd_ok;
   endsequence

   sequence s_data_done;
      (state_q != ST_CMD) && byte_evt;
   endsequence

   sequence s_unmapped_read;
      (state_q == ST_CMD) && byte_evt && cmd_ok && cmd_read && !cmd_is_io;
   endsequence

   AST_CMD_TO_WRITE: assert property (s_cmd_write |=> state_q == ST_WR) // RULE_04
      else $error("write command did not enter the data phase");

   AST_FRAME_END: assert property (cs_hi_s && !byte_evt |=> state_q == ST_CMD) // RULE_04
      else $error("released select did not end the frame");

   AST_OE_ZERO: assert property (io_wr |=> gp_pin_zero_oe == !$past(rx_byte[IO_P0DIR_BIT])) // RULE_08
      else $error("pin zero enable does not follow its direction bit");

   AST_OE_ONE: assert property (io_wr |=>
         sync_or_gp_pin_one_oe == (!$past(rx_byte[IO_P1DIR_BIT]) && !$past(rx_byte[IO_SYNC_BIT]))) // RULE_09
      else $error("pin one enable does not follow direction and sync bits");

   AST_DRIVE_VALUE: assert property (io_wr |=> gp_pin_zero_o == $past(rx_byte[IO_P0_BIT])) // RULE_11
      else $error("pin zero does not drive the written value");

   AST_READ_BACK: assert property (s_io_read |=> tx_q == $past(io_rd)) // RULE_08
      else $error("port register read returned a wrong value");

   AST_PIN_SAMPLE: assert property ((s_io_read and dir0_q) |=> tx_q[IO_P0_BIT] == $past(pin0_s)) // RULE_11
      else $error("input pin level not returned on read");

   AST_SYNC_HOLD: assert property (syncen_q && !sync_or_gp_pin_one_oe && !pin1_s |=> sync_hold) // RULE_10
      else $error("low sync pin did not hold the filter");

   AST_NO_HOLD: assert property (!syncen_q |=> !sync_hold) // RULE_10
      else $error("filter held while sync mode is off");

   AST_SYNC_INPUT: assert property (syncen_q |-> !sync_or_gp_pin_one_oe) // RULE_10
      else $error("pin one driven while acting as sync input");

   AST_MCLK_OFF: assert property (mclk_out_off ##1 mclk_out_off |-> !mclk_en_q) // RULE_07
      else $error("clock output not switched off");

   AST_CMD_TO_READ: assert property (s_cmd_read |=> state_q == ST_RD) // RULE_04
      else $error("read command did not enter the reply phase");

   AST_BAD_CMD: assert property (s_bad_cmd |=> state_q == ST_CMD) // RULE_04
      else $error("command with top bit set left the command phase");

   AST_DATA_DONE: assert property (s_data_done |=> state_q == ST_CMD) // RULE_04
      else $error("data byte did not return to the command phase");

   AST_UNMAPPED_READ: assert property (s_unmapped_read |=> tx_q == RD_UNMAPPED) // RULE_03
      else $error("unmapped read did not return the fill value");

   AST_DRIVE_ONE: assert property (io_wr |=> sync_or_gp_pin_one_o == $past(rx_byte[IO_P1_BIT])) // RULE_11
      else $error("pin one does not drive the written value");

   AST_RDYFN: assert property (io_wr |=> ready_fn == $past(rx_byte[IO_RDYFN_BIT])) // RULE_08
      else $error("ready function bit not stored");

   AST_SYNC_ENABLE: assert property (io_wr |=> syncen_q == $past(rx_byte[IO_SYNC_BIT])) // RULE_10
      else $error("sync enable bit not stored");

   AST_DIR_KEEP: assert property (!io_wr |=> $stable(dir0_q) && $stable(dir1_q)) // RULE_08
      else $error("direction bits changed without a port write");

   AST_PIN_ONE_SAMPLE: assert property ((s_io_read and dir1_q) |=> tx_q[IO_P1_BIT] == $past(pin1_s)) // RULE_11
      else $error("input level of pin one not returned on read");

   AST_CLOCK_ON: assert property (!mclk_out_off |=> mclk_en_q) // RULE_07
      else $error("clock output not switched back on");

endmodule // adcp_top

// >>> adcp_pkg.sv
// Shared constants and types of the converter control-pin block.
package adcp_pkg;

   // Serial unit length and synchroniser depth.
   localparam int          BYTE_W       = 8;
   localparam int          SYNC_STAGES  = 2;

   // Command byte layout: bit 7 must be zero, bit 6 selects a read, bits 5..0 address.
   localparam int          CMD_ZERO_BIT = 7;
   localparam int          CMD_RW_BIT   = 6;
   localparam int          ADDR_W       = 6;
   localparam logic [5:0]  ADDR_IO_PORT = 6'h01;

   // Port register field positions.
   localparam int          IO_P0_BIT    = 7;
   localparam int          IO_P1_BIT    = 6;
   localparam int          IO_P0DIR_BIT = 5;
   localparam int          IO_P1DIR_BIT = 4;
   localparam int          IO_RDYFN_BIT = 3;
   localparam int          IO_SYNC_BIT  = 0;

   // Power-on values; a direction bit of one means input.
   localparam logic        RST_DIR      = 1'b1;
   localparam logic        RST_VAL      = 1'b0;
   localparam logic        RST_RDYFN    = 1'b0;
   localparam logic        RST_SYNC     = 1'b0;
   localparam logic        RST_MCLK_EN  = 1'b1;
   localparam logic [7:0]  RD_UNMAPPED  = 8'h00;
   localparam logic [7:0]  RST_TX       = 8'h00;

   // Serial command decoder states.
   typedef enum logic [1:0] {
      ST_CMD,
      ST_WR,
      ST_RD
   } adcp_state_t;

endpackage

// >>> adcp_sync.sv
// Two-flop level synchroniser for a bundle of independent bits.
`timescale 1ns/10ps
module adcp_sync
   import adcp_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   // An empty bundle is refused when the design is built.
   if (W < 1) begin : g_w_check
      $error("adcp_sync: width must be at least one");
   end

   logic [W-1:0] meta_q;

   // The first stage is read by the second stage only.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule // adcp_sync

// >>> adcp_link.sv
// Serial-clock side of the host link: byte framing, receive shifter and transmit driver.
`timescale 1ns/10ps
module adcp_link
   import adcp_pkg::*;
#(
   parameter int BW = BYTE_W
) (
   input  wire logic          sclk,
   input  wire logic          arst_n,
   input  wire logic          cs_n,
   input  wire logic          din,
   input  wire logic [BW-1:0] tx_byte,
   output logic      [BW-1:0] rx_byte,
   output logic               rx_toggle,
   output logic               dout,
   output logic               dout_oe
);

   localparam int CW = $clog2(BW);

   // The shifter keeps all but the last bit, so a unit shorter than two bits cannot be served.
   if (BW < 2) begin : g_bw_check
      $error("adcp_link: byte width must be at least two");
   end

   logic [CW-1:0] cnt_q;
   logic [BW-2:0] shift_q;
   logic          lrst_n;
   wire  [BW-1:0] rx_full = {shift_q, din};
   wire           last_bit = (cnt_q == CW'(BW - 1));

   // A high select holds the framing in reset, so every select-low frame starts at bit 7.
   assign lrst_n = arst_n & ~cs_n; // RULE_03 RULE_04

   // Receive on the rising serial-clock edge, which only the host produces.
   always_ff @(posedge sclk or negedge lrst_n) begin // RULE_01
      if (!lrst_n) begin
         cnt_q   <= '0;
         shift_q <= '0;
      end else begin
         cnt_q   <= last_bit ? '0 : cnt_q + CW'(1); // RULE_04
         shift_q <= rx_full[BW-2:0];
      end
   end

   // Completed bytes survive a select release; only the chip reset clears them.
   always_ff @(posedge sclk or negedge arst_n) begin
      if (!arst_n) begin
         rx_byte   <= '0; // RULE_05
         rx_toggle <= 1'b0;
      end else if (last_bit) begin
         rx_byte   <= rx_full; // RULE_02
         rx_toggle <= ~rx_toggle;
      end
   end

   // Transmit on the falling edge; the output releases as soon as select goes high.
   always_ff @(negedge sclk or negedge lrst_n) begin
      if (!lrst_n) begin
         dout    <= 1'b0;
         dout_oe <= 1'b0; // RULE_03
      end else begin
         dout    <= tx_byte[CW'(BW - 1) - cnt_q]; // RULE_02
         dout_oe <= 1'b1;
      end
   end

endmodule // adcp_link

// >>> adcp_host.sv
// Host serial master model that clocks command and data units through the control pins.
`timescale 1ns/10ps
module adcp_host (
   output logic      sclk,
   output logic      cs_n,
   output logic      din,
   input  wire logic dout,
   input  wire logic dout_oe
);
   logic dout_w;
   logic last_q;

   // A released data line shows the inverse of its last level, so stale data never passes as a reply.
   always @* if (dout_oe) last_q = dout;
   assign dout_w = dout_oe ? dout : ~last_q;

   // The clock idles high and stands still between frames.
   initial begin
      sclk   = 1'b1;
      cs_n   = 1'b1;
      din    = 1'b0;
      last_q = 1'b0;
   end

   // One 8-bit unit, MSB first: drive on the falling edge, sample on the rising edge.
   task automatic unit(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sclk  = 1'b0;
         din   = tx[i];
         #62.5;
         sclk  = 1'b1;
         rx[i] = dout_w;
         #62.5;
      end
   endtask

   // Command and data unit in one frame; hold keeps the select low afterwards for 3-wire use.
   task automatic frame(input logic sel, input logic hold, input logic [7:0] cmd, input logic [7:0] dat,
                        output logic [7:0] rx);
      logic [7:0] unused;
      #1.7;
      cs_n = ~sel;
      #62.5;
      unit(cmd, unused);
      unit(dat, rx);
      #62.5;
      cs_n = hold ? ~sel : 1'b1;
      din  = ~din;
   endtask

   // A frame cut short after one command unit and n more bits; the partial unit must be dropped.
   task automatic cut(input logic [7:0] cmd, input int n);
      logic [7:0] unused;
      #1.7;
      cs_n = 1'b0;
      #62.5;
      unit(cmd, unused);
      for (int i = 0; i < n; i++) begin
         sclk = 1'b0;
         din  = 1'b1;
         #62.5;
         sclk = 1'b1;
         #62.5;
      end
      cs_n = 1'b1;
   endtask
endmodule // adcp_host

// >>> adcp_top_test.sv
// Self-checking bench for the converter control pins: reset, clock output, port register and link.
`timescale 1ns/10ps
module adcp_top_test;
   import adcp_pkg::*;
   localparam int LIMIT = 20000;
   logic       mclk, arst_n, sclk, cs_n, din, dout, dout_oe, mclk_out_off, master_clock_out;
   logic       p0_ext, p1_ext, p0_o, p0_oe, p1_o, p1_oe, p0_w, p1_w, sync_hold, ready_fn;
   logic [7:0] io_st;
   int         error_cnt, tests_run, cyc;

   // External ties on the pins lose to the device whenever it drives them.
   assign p0_w = p0_oe ? p0_o : p0_ext;
   assign p1_w = p1_oe ? p1_o : p1_ext;

   adcp_top i_dut (.mclk(mclk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
      .dout_oe(dout_oe), .mclk_out_off(mclk_out_off), .master_clock_out(master_clock_out),
      .gp_pin_zero_i(p0_w), .gp_pin_zero_o(p0_o), .gp_pin_zero_oe(p0_oe), .sync_or_gp_pin_one_i(p1_w),
      .sync_or_gp_pin_one_o(p1_o), .sync_or_gp_pin_one_oe(p1_oe), .sync_hold(sync_hold),
      .ready_fn(ready_fn), .io_port_status(io_st));
   adcp_host i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe));

   // Master clock at 200 MHz.
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // A hang is cut short by a cycle ceiling well above the expected run length.
   always @(posedge mclk) begin
      cyc++;
      if (cyc >= LIMIT) begin
         error_cnt++;
         end_sim();
      end
   end

   task automatic end_sim();
      if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] rx;
      i_host.frame(1'b1, 1'b0, {2'b00, a}, d, rx);
      wait_clk(10);
   endtask

   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      i_host.frame(1'b1, 1'b0, {2'b01, a}, 8'h00, d);
      wait_clk(10);
   endtask

   // Reset clears drivers and returns register fields to power-on values while the clock output keeps running.
   task automatic t_reset();
      arst_n = 1'b0;
      wait_clk(10);
      chk({3'h0, p0_oe, p1_oe, dout_oe, ready_fn, sync_hold}, 8'h00, "reset outputs");
      chk({7'h0, master_clock_out}, 8'h00, "clock out high phase");
      #2.5;
      chk({7'h0, master_clock_out}, 8'h01, "clock out low phase");
      wait_clk(1);
      arst_n = 1'b1;
      wait_clk(6);
      chk(io_st, {p0_ext, p1_ext, 6'h30}, "power-on port");
   endtask

   // Switching the clock output off holds it low.
   task automatic t_clkout();
      mclk_out_off = 1'b1;
      wait_clk(2);
      #2.5;
      chk({7'h0, master_clock_out}, 8'h00, "clock out off");
      wait_clk(1);
      mclk_out_off = 1'b0;
      wait_clk(2);
      #2.5;
      chk({7'h0, master_clock_out}, 8'h01, "clock out on");
      wait_clk(1);
   endtask

   // Both pins as outputs, read back and rewritten over a 3-wire pair of frames with select held low.
   task automatic t_gpio_out();
      logic [7:0] r;
      wr(ADDR_IO_PORT, 8'hc8);
      chk({3'h0, p0_oe, p0_o, p1_oe, p1_o, ready_fn}, 8'h1f, "pins driven");
      chk(io_st, 8'hc8, "port status");
      i_host.frame(1'b1, 1'b1, 8'h41, 8'h00, r);
      chk(r, 8'hc8, "3-wire read");
      i_host.frame(1'b1, 1'b0, 8'h01, 8'h08, r);
      wait_clk(10);
      chk({6'h0, p0_o, p1_o}, 8'h00, "3-wire write");
   endtask

   // Pins as inputs read back their sampled levels.
   task automatic t_gpio_in();
      logic [7:0] r;
      p0_ext = 1'b0;
      p1_ext = 1'b1;
      wr(ADDR_IO_PORT, 8'h38);
      rd(ADDR_IO_PORT, r);
      chk(r, 8'h78, "input read");
      chk({6'h0, p0_oe, p1_oe}, 8'h00, "inputs undriven");
   endtask

   // Sync mode releases pin one even when its direction says output; a low pin holds the filter.
   task automatic t_sync();
      wr(ADDR_IO_PORT, 8'h21);
      p1_ext = 1'b0;
      wait_clk(6);
      chk({6'h0, p1_oe, sync_hold}, 8'h01, "sync low holds");
      p1_ext = 1'b1;
      wait_clk(6);
      chk({6'h0, p1_oe, sync_hold}, 8'h00, "sync high runs");
   endtask

   // Unselected frames and unmapped addresses leave the port alone.
   task automatic t_refuse();
      logic [7:0] r;
      wr(ADDR_IO_PORT, 8'h38);
      i_host.frame(1'b0, 1'b0, 8'h01, 8'h0c, r);
      wait_clk(10);
      chk(io_st, 8'h78, "unselected write");
      wr(6'h02, 8'h0c);
      chk(io_st, 8'h78, "unmapped write");
      rd(6'h02, r);
      chk(r, RD_UNMAPPED, "unmapped read");
   endtask

   // A cut frame and commands with the top bit set leave the port alone and keep the framing.
   task automatic t_frame();
      logic [7:0] r;
      i_host.cut(8'h01, 3);
      wait_clk(4);
      chk(io_st, 8'h78, "cut frame");
      i_host.frame(1'b1, 1'b0, 8'h81, 8'hc1, r);
      wait_clk(10);
      chk(io_st, 8'h78, "bad command");
      wr(ADDR_IO_PORT, 8'hc8);
      chk(io_st, 8'hc8, "write after cut");
   endtask

   // Main sequence; inputs change one nanosecond after the rising edge.
   initial begin
      arst_n       = 1'b0;
      mclk_out_off = 1'b0;
      p0_ext       = 1'b1;
      p1_ext       = 1'b0;
      error_cnt    = 0;
      tests_run    = 0;
      cyc          = 0;
      t_reset();
      t_clkout();
      t_gpio_out();
      t_reset();
      t_gpio_in();
      t_sync();
      t_refuse();
      t_frame();
      end_sim();
   end
endmodule // adcp_top_test
